// ### rtl/dbs_top.sv
// dbs_top: 32-bit processor bus to 32/16/8-bit dynamic port bus sizer
//
// Functional notes
// RULE1: select starts access; acknowledge ends it
// RULE2: access splits into one, two, four transfers
// RULE3: both size acks high keep transfer waiting
// RULE4: ack codes give port width; adapt remainder
// RULE5: width code: byte, word or long word
// RULE6: byte offset picks the processor byte lane
// RULE7: port byte address names moved byte
// RULE8: 16-bit writes: upper and lower lane enables
// RULE9: 8-bit writes: single lane enable per byte
// RULE10: strobe marks read window or valid write data
// RULE11: low data half tristate until width known
// RULE12: system gates low transceivers for 32-bit ports
// RULE13: port transfers paced by acknowledge, clock synchronous
// RULE14: 8-bit port bytes travel on upper lane
// RULE15: long read from 8-bit port: four transfers
// RULE16: one-cycle acknowledge, then back to idle
`timescale 1ns/1ps
module dbs_top
  import dbs_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic CS_N_IN,
  input wire logic RW_IN,
  input wire logic [1:0] TRANSFER_WIDTH_IN,
  input wire logic [1:0] BYTE_OFFSET_IN,
  input wire logic [31:0] CPU_DATA_IN,
  output logic [31:0] CPU_DATA_OUT,
  output logic CPU_DATA_HI_OE_OUT,
  output logic CPU_DATA_LO_OE_OUT,
  output logic ACCESS_DONE_ACK_N_OUT,
  input wire logic [1:0] PORT_SIZE_ACK_IN,
  input wire logic [15:0] PORT_DATA_IN,
  output logic [15:0] PORT_DATA_OUT,
  output logic PORT_DATA_OE_OUT,
  output logic [1:0] PORT_BYTE_ADDR_OUT,
  output logic PORT_STROBE_N_OUT,
  output logic UPPER_LANE_WRITE_EN_N_OUT,
  output logic LOWER_LANE_WRITE_EN_N_OUT,
  output logic SINGLE_LANE_WRITE_EN_N_OUT
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  dbs_top_st_t q;
  dbs_top_st_t d;
  logic [1:0] first_lane;
  logic [1:0] last_lane;
  logic [1:0] next_lane;
  logic final_xfer;
  logic port_ack;
  logic in_access;
  dbs_rec_t push_rec;
  dbs_rec_t pop_rec;

  dbs_stream_if #(.W(REC_W)) rec_in ();
  dbs_stream_if #(.W(REC_W)) rec_out ();

  // ****************************************************************
  // helpers
  // ****************************************************************
  // lane range comes from the live pins, stepping from the held access
  dbs_step u_step (
    .width_in(TRANSFER_WIDTH_IN), // RULE5
    .offset_in(BYTE_OFFSET_IN), // RULE6
    .addr_in(q.addr),
    .last_in(q.last),
    .psize_in(PORT_SIZE_ACK_IN),
    .first_out(first_lane),
    .last_out(last_lane),
    .next_out(next_lane),
    .final_out(final_xfer)
  );

  // finished transfers queue here so a busy merge stage never drops one
  dbs_buf #(.W(REC_W), .DEPTH(BUF_DEPTH)) u_buf (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RESETN_IN),
    .push(rec_in.snk),
    .pop(rec_out.src)
  );

  // port acknowledge seen with any width code ends the current transfer
  assign port_ack = (q.st == ST_STROBE) && (PORT_SIZE_ACK_IN != ACK_WAIT); // RULE3
  assign push_rec = '{addr: q.addr, size: PORT_SIZE_ACK_IN, data: PORT_DATA_IN};
  assign rec_in.valid = port_ack;
  assign rec_in.data = push_rec;
  assign pop_rec = dbs_rec_t'(rec_out.data);
  // merging waits while a strobe is out, so the buffer really takes up slack
  assign rec_out.ready = (q.st != ST_STROBE) && !q.ack;

  // ****************************************************************
  // access sequencer and read merge
  // ****************************************************************
  // one state copy per cycle: sequence transfers and merge read bytes
  always_comb begin
    d = q;
    d.ack = 1'b0;
    unique case (q.st)
      ST_IDLE: begin
        if (!CS_N_IN) begin // RULE1
          d.rd = RW_IN;
          d.wcode = TRANSFER_WIDTH_IN;
          d.addr = first_lane; // RULE7
          d.last = last_lane;
          d.wdata = CPU_DATA_IN;
          d.pdata = wr_lanes(CPU_DATA_IN, first_lane);
          d.size_known = 1'b0;
          d.xfers = XFER_RST;
          d.st = ST_STROBE;
        end
      end
      ST_STROBE: begin
        // held here while the peripheral answers wait, any length of time
        if (port_ack && rec_in.ready) begin // RULE13
          d.psize = PORT_SIZE_ACK_IN; // RULE4
          d.size_known = 1'b1;
          d.xfers = q.xfers + 3'h1;
          if (final_xfer) begin // RULE2
            d.st = ST_DRAIN;
          end else begin
            d.addr = next_lane; // RULE4
            d.pdata = wr_lanes(q.wdata, next_lane);
            d.st = ST_GAP;
          end
        end
      end
      ST_GAP: begin
        // the peripheral must drop its acknowledge before the next strobe
        if (PORT_SIZE_ACK_IN == ACK_WAIT) begin
          d.st = ST_STROBE;
        end
      end
      ST_DRAIN: begin
        if (!rec_out.valid) begin
          d.ack = 1'b1; // RULE1
          d.st = ST_DONE;
        end
      end
      ST_DONE: begin
        d.st = ST_REARM; // RULE16
      end
      ST_REARM: begin
        // a select still held from the finished access must not restart it
        if (CS_N_IN) begin
          d.st = ST_IDLE; // RULE16
        end
      end
    endcase
    // place each finished read transfer into its processor lanes
    if (rec_out.valid && rec_out.ready && q.rd) begin
      unique case (pop_rec.size)
        ACK_8: begin
          d.rdata = put_byte(q.rdata, pop_rec.addr, pop_rec.data[15:8]); // RULE14
        end
        ACK_16: begin
          d.rdata = put_byte(q.rdata, pop_rec.addr & LANE_HALF, pop_rec.data[15:8]);
          d.rdata = put_byte(d.rdata, pop_rec.addr | 2'h1, pop_rec.data[7:0]);
        end
        default: begin
          d.rdata[31:16] = pop_rec.data; // low half comes through external transceivers
        end
      endcase
    end
  end

  // synchronous reset into idle with no strobe and no acknowledge
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESETN_IN) begin
      q <= TOP_RST;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // pins
  // ****************************************************************
  assign in_access = (q.st == ST_STROBE) || (q.st == ST_GAP) || (q.st == ST_DRAIN) ||
                     (q.st == ST_DONE);
  assign CPU_DATA_OUT = q.rdata;
  assign CPU_DATA_HI_OE_OUT = q.rd && in_access;
  // low half stays off the bus until a narrow port is known
  assign CPU_DATA_LO_OE_OUT = q.rd && in_access && q.size_known && (q.psize != ACK_32); // RULE11
  assign ACCESS_DONE_ACK_N_OUT = !q.ack; // RULE16
  assign PORT_STROBE_N_OUT = !(q.st == ST_STROBE); // RULE10
  assign PORT_BYTE_ADDR_OUT = q.addr; // RULE7
  assign PORT_DATA_OUT = q.pdata; // RULE14
  assign PORT_DATA_OE_OUT = !q.rd && ((q.st == ST_STROBE) || (q.st == ST_GAP));
  // width unknown on the first strobe, so every enable that fits the lane goes out
  assign UPPER_LANE_WRITE_EN_N_OUT = !(!q.rd && (q.st == ST_STROBE) && !q.addr[0]); // RULE8
  assign LOWER_LANE_WRITE_EN_N_OUT = !(!q.rd && (q.st == ST_STROBE) &&
                                       (q.addr[0] || (q.last > q.addr))); // RULE8
  assign SINGLE_LANE_WRITE_EN_N_OUT = !(!q.rd && (q.st == ST_STROBE)); // RULE9

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_access_start: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN) // RULE1
    (q.st == ST_IDLE && !CS_N_IN) |=>
      (q.st == ST_STROBE && !PORT_STROBE_N_OUT && PORT_BYTE_ADDR_OUT == $past(first_lane)))
    else $error("select did not start a strobed transfer at the first lane");

  chk_wait_holds: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN) // RULE3
    (q.st == ST_STROBE && PORT_SIZE_ACK_IN == ACK_WAIT) |=>
      (q.st == ST_STROBE && q.xfers == $past(q.xfers)))
    else $error("transfer completed while acknowledge was wait");

  chk_half_step: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN) // RULE4
    (port_ack && rec_in.ready && PORT_SIZE_ACK_IN == ACK_16 && !final_xfer) |=>
      (q.st == ST_GAP && PORT_BYTE_ADDR_OUT == LANE_HALF && PORT_STROBE_N_OUT))
    else $error("16-bit port did not step to the second half-word");

  chk_four_bytes: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN) // RULE15
    (q.ack && q.psize == ACK_8 && q.wcode != TW_BYTE && q.wcode != TW_WORD) |->
      q.xfers == 3'h4)
    else $error("long word over 8-bit port did not take four transfers");

  chk_lo_tristate: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN) // RULE11
    (!q.size_known || q.psize == ACK_32) |-> !CPU_DATA_LO_OE_OUT)
    else $error("low data half driven before a narrow width was known");

  chk_upper_lane: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN) // RULE8
    !UPPER_LANE_WRITE_EN_N_OUT |-> (!PORT_BYTE_ADDR_OUT[0] && !PORT_STROBE_N_OUT && !q.rd))
    else $error("upper lane enable on an odd byte or outside a write strobe");

  chk_single_lane: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN) // RULE9
    !SINGLE_LANE_WRITE_EN_N_OUT |->
      (PORT_DATA_OE_OUT && PORT_DATA_OUT[15:8] == lane_of(q.wdata, PORT_BYTE_ADDR_OUT)))
    else $error("single lane enable without the addressed byte on the port");

  chk_byte_merge: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN) // RULE14
    (rec_out.valid && rec_out.ready && q.rd && pop_rec.size == ACK_8) |=>
      lane_of(CPU_DATA_OUT, $past(pop_rec.addr)) == $past(pop_rec.data[15:8]))
    else $error("8-bit read byte not placed in its processor lane");

  chk_ack_pulse: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN) // RULE16
    $fell(ACCESS_DONE_ACK_N_OUT) |=>
      (ACCESS_DONE_ACK_N_OUT && q.st == ST_REARM) ##1 ACCESS_DONE_ACK_N_OUT)
    else $error("acknowledge longer than one cycle or no return toward idle");

  // address and data must not move while the peripheral is still waiting
  chk_strobe_steady: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN) // RULE3
    (q.st == ST_STROBE && PORT_SIZE_ACK_IN == ACK_WAIT) |=>
      (!PORT_STROBE_N_OUT && $stable(PORT_BYTE_ADDR_OUT) && $stable(PORT_DATA_OUT)))
    else $error("strobe, address or write data moved during a wait");

  // a taken acknowledge closes the strobe on the next cycle
  chk_strobe_ends: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN) // RULE10
    (port_ack && rec_in.ready) |=> PORT_STROBE_N_OUT)
    else $error("strobe still low after the transfer was acknowledged");

  // the next strobe follows once the peripheral is back at wait
  chk_gap_rearm: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN) // RULE13
    (q.st == ST_GAP && PORT_SIZE_ACK_IN == ACK_WAIT) |=> !PORT_STROBE_N_OUT)
    else $error("no strobe after the acknowledge returned to wait");

  // a stale acknowledge must not open the next transfer
  chk_gap_waits: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN) // RULE13
    (q.st == ST_GAP && PORT_SIZE_ACK_IN != ACK_WAIT) |=> PORT_STROBE_N_OUT)
    else $error("strobe reopened while the old acknowledge still stood");

  // nothing on either bus moves between accesses
  chk_idle_quiet: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN) // RULE10
    (q.st == ST_IDLE || q.st == ST_REARM) |->
      (PORT_STROBE_N_OUT && ACCESS_DONE_ACK_N_OUT && SINGLE_LANE_WRITE_EN_N_OUT &&
       !CPU_DATA_HI_OE_OUT))
    else $error("strobe, enable, acknowledge or data drive outside an access");

  // an 8-bit port steps one byte address per transfer
  chk_byte_step: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN) // RULE15
    (port_ack && rec_in.ready && PORT_SIZE_ACK_IN == ACK_8 && !final_xfer) |=>
      (PORT_BYTE_ADDR_OUT == $past(PORT_BYTE_ADDR_OUT) + 2'h1))
    else $error("8-bit port did not step to the next byte address");

  // lower lane enable only inside a write strobe
  chk_lower_lane: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN) // RULE8
    !LOWER_LANE_WRITE_EN_N_OUT |-> (!PORT_STROBE_N_OUT && !q.rd))
    else $error("lower lane enable outside a write strobe");

  // write strobe carries the addressed lane and its odd partner
  chk_write_data: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN) // RULE10
    (q.st == ST_STROBE && !q.rd) |->
      (PORT_DATA_OE_OUT && PORT_DATA_OUT == wr_lanes(q.wdata, PORT_BYTE_ADDR_OUT)))
    else $error("write strobe without the addressed lanes on the port");

  // a read strobe leaves the port data free for the peripheral
  chk_read_quiet: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN) // RULE10
    (q.st == ST_STROBE && q.rd) |->
      (!PORT_DATA_OE_OUT && SINGLE_LANE_WRITE_EN_N_OUT && UPPER_LANE_WRITE_EN_N_OUT))
    else $error("port data or write enable driven during a read strobe");

  // acknowledge only once every transfer has been merged
  chk_ack_last: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN) // RULE1
    q.ack |-> (!rec_out.valid && q.xfers != XFER_RST))
    else $error("acknowledge with transfers still queued or none done");

  // an access ends after one, two or four transfers
  chk_done_count: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN) // RULE2
    q.ack |-> (q.xfers == 3'h1 || q.xfers == 3'h2 || q.xfers == 3'h4))
    else $error("access ended after an unexpected number of transfers");

endmodule : dbs_top

// ### rtl/dbs_pkg.sv
// dbs_pkg: shared codes, records, state types and lane helpers of the bus sizer
package dbs_pkg;

  // ****************************************************************
  // link codes
  // ****************************************************************
  // port size acknowledge, raw pin levels (1 = high)
  localparam logic [1:0] ACK_WAIT = 2'h3;
  localparam logic [1:0] ACK_8 = 2'h2;
  localparam logic [1:0] ACK_16 = 2'h1;
  localparam logic [1:0] ACK_32 = 2'h0;
  // transfer width requested by the processor; 00 and 11 both mean long word
  localparam logic [1:0] TW_BYTE = 2'h1;
  localparam logic [1:0] TW_WORD = 2'h2;
  // port byte addresses: 00 is the most significant byte
  localparam logic [1:0] LANE_MSB = 2'h0;
  localparam logic [1:0] LANE_HALF = 2'h2;
  localparam logic [1:0] LANE_LSB = 2'h3;
  localparam int REC_W = 20;
  localparam int BUF_DEPTH = 2;
  localparam logic [2:0] XFER_RST = 3'h0;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {ST_IDLE, ST_STROBE, ST_GAP, ST_DRAIN, ST_DONE, ST_REARM} dbs_state_t;

  // one completed peripheral transfer
  typedef struct packed {
    logic [1:0] addr;
    logic [1:0] size;
    logic [15:0] data;
  } dbs_rec_t;

  typedef struct packed {
    dbs_state_t st;
    logic rd;
    logic [1:0] wcode;
    logic [1:0] addr;
    logic [1:0] last;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [15:0] pdata;
    logic [1:0] psize;
    logic size_known;
    logic ack;
    logic [2:0] xfers;
  } dbs_top_st_t;

  localparam dbs_top_st_t TOP_RST = '0;

  // ****************************************************************
  // lane helpers
  // ****************************************************************
  // byte of a processor word by lane number, lane 0 = bits 31:24
  function automatic logic [7:0] lane_of(input logic [31:0] w, input logic [1:0] l);
    lane_of = w[8*(3-int'(l)) +: 8];
  endfunction : lane_of

  // replace one lane of a word
  function automatic logic [31:0] put_byte(input logic [31:0] w, input logic [1:0] l,
                                           input logic [7:0] b);
    put_byte = w;
    put_byte[8*(3-int'(l)) +: 8] = b;
  endfunction : put_byte

  // write data for the port: upper byte from the addressed lane, lower from its odd partner
  function automatic logic [15:0] wr_lanes(input logic [31:0] w, input logic [1:0] a);
    wr_lanes = {lane_of(w, a), lane_of(w, a | 2'h1)};
  endfunction : wr_lanes

endpackage : dbs_pkg

// ### rtl/dbs_stream_if.sv
// dbs_stream_if: valid/ready word stream between the sizer's own modules
`timescale 1ns/1ps
interface dbs_stream_if #(parameter int W = 20);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : dbs_stream_if

// ### rtl/dbs_buf.sv
// dbs_buf: small valid/ready buffer holding completed peripheral transfers
`timescale 1ns/1ps
module dbs_buf
  import dbs_pkg::*;
#(
  parameter int W = REC_W,
  parameter int DEPTH = BUF_DEPTH
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  dbs_stream_if.snk push,
  dbs_stream_if.src pop
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } dbs_buf_st_t;

  dbs_buf_st_t q;
  dbs_buf_st_t d;
  logic in_fire;
  logic out_fire;

  // full and empty come straight from the count, so back-pressure is exact
  assign push.ready = (q.cnt != (AW+1)'(DEPTH));
  assign pop.valid = (q.cnt != '0);
  assign pop.data = q.mem[q.rp];
  assign in_fire = push.valid && push.ready;
  assign out_fire = pop.valid && pop.ready;

  // next state: write at wp, read at rp, pointers wrap at DEPTH
  always_comb begin
    d = q;
    if (in_fire) begin
      d.mem[q.wp] = push.data;
      d.wp = (q.wp == AW'(DEPTH-1)) ? '0 : q.wp + 1'b1;
    end
    if (out_fire) begin
      d.rp = (q.rp == AW'(DEPTH-1)) ? '0 : q.rp + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(in_fire) - (AW+1)'(out_fire);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // a taken word with no pop must raise the count by one, never past the depth
  chk_buf_no_overrun: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (in_fire && !out_fire) |=> (q.cnt == $past(q.cnt) + 1'b1 && q.cnt <= (AW+1)'(DEPTH)))
    else $error("buffer count not raised by one on a push or past depth");

endmodule : dbs_buf

// ### rtl/dbs_step.sv
// dbs_step: lane range of an access and the step from one transfer to the next
`timescale 1ns/1ps
module dbs_step
  import dbs_pkg::*;
(
  input wire logic [1:0] width_in,
  input wire logic [1:0] offset_in,
  input wire logic [1:0] addr_in,
  input wire logic [1:0] last_in,
  input wire logic [1:0] psize_in,
  output logic [1:0] first_out,
  output logic [1:0] last_out,
  output logic [1:0] next_out,
  output logic final_out
);
  // first and last lane touched by the processor access
  always_comb begin
    unique case (width_in)
      TW_BYTE: begin
        first_out = offset_in;
        last_out = offset_in;
      end
      TW_WORD: begin
        first_out = {offset_in[1], 1'b0};
        last_out = {offset_in[1], 1'b1};
      end
      default: begin
        first_out = LANE_MSB;
        last_out = LANE_LSB;
      end
    endcase
  end

  // a 16-bit port moves a half-word, an 8-bit port a single byte
  always_comb begin
    unique case (psize_in)
      ACK_32: begin
        next_out = addr_in;
        final_out = 1'b1;
      end
      ACK_16: begin
        next_out = LANE_HALF;
        final_out = ((addr_in | 2'h1) >= last_in);
      end
      ACK_8: begin
        next_out = addr_in + 2'h1; // RULE15
        final_out = (addr_in >= last_in);
      end
      default: begin
        next_out = addr_in;
        final_out = 1'b0;
      end
    endcase
  end

endmodule : dbs_step

// ### sim/dbs_periph.sv
// dbs_periph: behavioural peripheral on the sizer's port side
`timescale 1ns/1ps
module dbs_periph
  import dbs_pkg::*;
(
  input wire logic clk_in,
  input wire logic strobe_n_in,
  input wire logic [1:0] addr_in,
  input wire logic [15:0] data_in,
  input wire logic data_oe_in,
  input wire logic uwe_n_in,
  input wire logic lwe_n_in,
  input wire logic swe_n_in,
  input wire logic [1:0] size_in,
  input wire logic [7:0] wait_in,
  output logic [1:0] ack_out,
  output logic [15:0] data_out
);
  // ****************************************************************
  // storage and handshake
  // ****************************************************************
  logic [7:0] mem [4];
  logic [7:0] cnt;

  initial begin
    ack_out = ACK_WAIT;
    data_out = 16'h0000;
    cnt = 8'h00;
  end

  // ack only after the strobe and the wait count; idle data toggles so stale bytes never match
  always @(posedge clk_in) begin
    if (strobe_n_in !== 1'b0) begin
      ack_out <= ACK_WAIT;
      cnt <= 8'h00;
      data_out <= ~data_out;
    end else if (ack_out != ACK_WAIT) begin
      if (data_oe_in && size_in == ACK_8 && !swe_n_in) begin
        mem[addr_in] <= data_in[15:8];
      end else if (data_oe_in && size_in != ACK_8) begin
        if (!uwe_n_in) mem[addr_in] <= data_in[15:8];
        if (!lwe_n_in) mem[addr_in | 2'h1] <= data_in[7:0];
      end
    end else if (cnt < wait_in) begin
      cnt <= cnt + 8'h01;
      data_out <= ~data_out;
    end else begin
      ack_out <= size_in;
      if (size_in == ACK_8) data_out <= {mem[addr_in], ~mem[addr_in]};
      else data_out <= {mem[addr_in], mem[addr_in | 2'h1]};
    end
  end
endmodule : dbs_periph

// ### sim/tb.sv
// tb: self-checking bench of the dynamic bus sizer
`timescale 1ns/1ps
module tb;
  import dbs_pkg::*;
  // ****************************************************************
  // signals and instances
  // ****************************************************************
  logic clk, rst_n, cs_n, rw;
  logic [1:0] tw, off, psize, pack;
  logic [7:0] pwait;
  logic [31:0] wdata, cpu_q;
  logic [15:0] pd_in, pd_out;
  logic hi_oe, lo_oe, ack_n, pd_oe, stb_n, uwe_n, lwe_n, swe_n, stb_q, lo_seen, hi_seen;
  logic [1:0] paddr;
  logic [1:0] alog [8];
  int n_xfer, miscompares, compares, cycles;

  dbs_top u_dut (.CORE_CLK_IN(clk), .RESETN_IN(rst_n), .CS_N_IN(cs_n), .RW_IN(rw),
    .TRANSFER_WIDTH_IN(tw), .BYTE_OFFSET_IN(off), .CPU_DATA_IN(wdata),
    .CPU_DATA_OUT(cpu_q), .CPU_DATA_HI_OE_OUT(hi_oe), .CPU_DATA_LO_OE_OUT(lo_oe),
    .ACCESS_DONE_ACK_N_OUT(ack_n), .PORT_SIZE_ACK_IN(pack), .PORT_DATA_IN(pd_in),
    .PORT_DATA_OUT(pd_out), .PORT_DATA_OE_OUT(pd_oe), .PORT_BYTE_ADDR_OUT(paddr),
    .PORT_STROBE_N_OUT(stb_n), .UPPER_LANE_WRITE_EN_N_OUT(uwe_n),
    .LOWER_LANE_WRITE_EN_N_OUT(lwe_n), .SINGLE_LANE_WRITE_EN_N_OUT(swe_n));

  dbs_periph u_per (.clk_in(clk), .strobe_n_in(stb_n), .addr_in(paddr), .data_in(pd_out),
    .data_oe_in(pd_oe), .uwe_n_in(uwe_n), .lwe_n_in(lwe_n), .swe_n_in(swe_n),
    .size_in(psize), .wait_in(pwait), .ack_out(pack), .data_out(pd_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // log the byte address of every strobe start; a hang is cut short by the cycle ceiling
  always @(posedge clk) begin
    stb_q <= stb_n;
    if (stb_q === 1'b1 && stb_n === 1'b0 && n_xfer < 8) begin
      alog[n_xfer] = paddr;
      n_xfer++;
    end
    if (lo_oe === 1'b1) lo_seen = 1'b1;
    if (hi_oe === 1'b1) hi_seen = 1'b1;
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report

  // one processor access; hold keeps select low after the acknowledge
  task automatic access(input logic r, input logic [1:0] w, input logic [1:0] o,
                        input logic [31:0] d, input logic hold, output int cyc);
    n_xfer = 0;
    lo_seen = 1'b0;
    hi_seen = 1'b0;
    cyc = 0;
    @(posedge clk);
    cs_n <= 1'b0;
    rw <= r;
    tw <= w;
    off <= o;
    wdata <= d;
    do begin
      @(posedge clk);
      cyc++;
    end while (ack_n !== 1'b0 && cyc < 300);
    check(cyc < 300, 1);
    if (!hold) cs_n <= 1'b1;
    @(posedge clk);
    check({31'h0, ack_n}, 32'h0000_0001);
  endtask : access

  task automatic setup(input logic [1:0] s, input logic [7:0] wt, input logic [31:0] m);
    psize = s;
    pwait = wt;
    for (int i = 0; i < 4; i++) u_per.mem[i] = m[8*(3-i) +: 8];
  endtask : setup

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_long_rd8();
    int c;
    setup(ACK_8, 8'h01, 32'hA1B2_C3D4);
    access(1'b1, 2'h0, 2'h0, 32'h0000_0000, 1'b0, c);
    check(cpu_q, 32'hA1B2_C3D4);
    check(n_xfer, 4);
    for (int i = 0; i < 4; i++) check(alog[i], i);
    $display("test long read 8-bit done");
  endtask : t_long_rd8

  task automatic t_long_wr16();
    int c;
    setup(ACK_16, 8'h02, 32'h0000_0000);
    access(1'b0, 2'h0, 2'h0, 32'h1122_3344, 1'b0, c);
    check({u_per.mem[0], u_per.mem[1], u_per.mem[2], u_per.mem[3]}, 32'h1122_3344);
    check(n_xfer, 2);
    check({alog[0], alog[1], hi_seen}, {LANE_MSB, LANE_HALF, 1'b0});
    $display("test long write 16-bit done");
  endtask : t_long_wr16

  task automatic t_byte_wr8();
    int c;
    setup(ACK_8, 8'h00, 32'h0000_0000);
    for (int k = 0; k < 4; k++) begin
      access(1'b0, TW_BYTE, k[1:0], 32'h5566_7788, 1'b0, c);
      check(u_per.mem[k], 8'h55 + 8'h11 * k);
      check({n_xfer[1:0], alog[0]}, {2'h1, k[1:0]});
    end
    $display("test byte writes 8-bit done");
  endtask : t_byte_wr8

  task automatic t_word_rd32();
    int c;
    setup(ACK_32, 8'h00, 32'h0102_0304);
    access(1'b1, TW_WORD, 2'h0, 32'h0000_0000, 1'b0, c);
    check(cpu_q[31:16], 16'h0102);
    check({n_xfer[29:0], hi_seen, lo_seen}, {30'h1, 1'b1, 1'b0});
    $display("test word read 32-bit done");
  endtask : t_word_rd32

  task automatic t_wait_rd();
    int c;
    setup(ACK_16, 8'h06, 32'h9ABC_DEF0);
    access(1'b1, 2'h3, 2'h0, 32'h0000_0000, 1'b0, c);
    check(cpu_q, 32'h9ABC_DEF0);
    check(c >= 16, 1);
    setup(ACK_8, 8'h03, 32'h1357_9BDF);
    access(1'b1, TW_WORD, 2'h2, 32'h0000_0000, 1'b0, c);
    check(cpu_q[15:0], 16'h9BDF);
    check({alog[0], alog[1], lo_seen}, {2'h2, LANE_LSB, 1'b1});
    $display("test wait states done");
  endtask : t_wait_rd

  task automatic t_hold_sel();
    int c;
    setup(ACK_32, 8'h00, 32'h0000_0000);
    access(1'b1, TW_BYTE, 2'h1, 32'h0000_0000, 1'b1, c);
    n_xfer = 0;
    repeat (10) @(posedge clk);
    check(n_xfer, 0);
    check({31'h0, ack_n}, 32'h0000_0001);
    cs_n <= 1'b1;
    $display("test held select done");
  endtask : t_hold_sel

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    cs_n = 1'b1;
    rw = 1'b1;
    tw = 2'h0;
    off = 2'h0;
    wdata = 32'h0000_0000;
    psize = ACK_32;
    pwait = 8'h00;
    stb_q = 1'b1;
    lo_seen = 1'b0;
    hi_seen = 1'b0;
    n_xfer = 0;
    miscompares = 0;
    compares = 0;
    cycles = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_long_rd8();
    t_long_wr16();
    t_byte_wr8();
    t_word_rd32();
    t_wait_rd();
    t_hold_sel();
    repeat (3) @(posedge clk);
    final_report();
  end
endmodule : tb
